// ---- common/eep_pkg.sv ----
// Shared constants and types for the two-wire EEPROM read engine.
// Assumes a single device clock; the bus pins are sampled, not clocked.
package eep_pkg;

    localparam int          DATA_W        = 8;
    localparam int          MEM_AW        = 10;
    localparam int          MEM_DEPTH     = 1024;
    localparam int          BUF_DEPTH     = 2;

    // Target address byte layout.
    localparam logic [3:0]  DEV_CODE      = 4'ha;
    localparam int          CODE_MSB      = 7;
    localparam int          CODE_LSB      = 4;
    localparam int          UPPER_MSB     = 3;
    localparam int          UPPER_LSB     = 2;
    localparam int          DIR_BIT       = 0;
    localparam logic        DIR_READ      = 1'b1;

    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [MEM_AW-1:0] ADDR_RESET = 10'h000;
    localparam logic [1:0]  UPPER_RESET   = 2'h0;
    localparam logic        SDA_LOW       = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_RX_DEV   = 4'h1,
        ST_RX_MEM   = 4'h2,
        ST_ACK_WAIT = 4'h3,
        ST_ACK_DRV  = 4'h4,
        ST_TX_BIT   = 4'h5,
        ST_TX_ACK   = 4'h6,
        ST_TX_MORE  = 4'h7,
        ST_IGNORE   = 4'h8
    } eep_state_t;

    // One prefetched byte together with the address it came from.
    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
    } eep_word_t;

endpackage

// ---- verilog/eep_fifo2.sv ----
// Small flushable FIFO between the array prefetch and the bit shifter.
// Assumes DEPTH is a power of two; flush wins over a push in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module eep_fifo2 import eep_pkg::*; #(
    parameter int W     = 18,
    parameter int DEPTH = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic         i_flush,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  slot_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign o_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_valid = (cnt_r != '0);
    assign o_data  = slot_r[rd_ptr_r];
    assign push    = i_valid && o_ready && !i_flush;
    assign pop     = o_valid && i_ready && !i_flush;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt    = cnt_r;
        if (i_flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            cnt_nxt    = '0;
        end else begin
            if (push) begin
                wr_ptr_nxt = wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_nxt = rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_nxt = cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r    <= cnt_nxt;
        end
    end

    // Storage needs no reset: the count decides what is valid.
    always_ff @(posedge i_clk) begin
        if (push) begin
            slot_r[wr_ptr_r] <= i_data;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/eep_read_engine.sv ----
// Read path of a two-wire serial EEPROM target with a 1024 x 8 array.
// Assumes SCL and SDA arrive asynchronously and are oversampled by i_clk;
// SCL must stay well below a quarter of the i_clk rate.
// Operation
// - On a matching read address the device acknowledges and sends the byte at the current address.
// - After a not-acknowledge and STOP the device releases the data line and returns to idle.
// - The device acknowledges the word address byte, loads that address and then ignores the bus until the next START.
// - While the controller acknowledges, the device keeps sending the following byte.
// - The address increments after each byte sent and wraps to zero past the last location.
// - Only address bytes whose top four bits match the fixed code are taken, with two upper address bits and a direction bit.
// - On the ninth clock the transmitter releases the data line so the receiver can answer.
// - Incoming bits are sampled on the clock rise and outgoing bits change on the clock fall.
// - While an internal write cycle runs the device leaves its own address unacknowledged.
`timescale 1ns/1ps
`default_nettype none
module eep_read_engine import eep_pkg::*; (
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda_o,
    output logic                   o_sda_oe,
    input  wire logic              i_wr_busy,
    input  wire logic              i_load_en,
    input  wire logic [MEM_AW-1:0] i_load_addr,
    input  wire logic [DATA_W-1:0] i_load_data,
    output logic [MEM_AW-1:0]      o_cur_addr
);
    logic [DATA_W-1:0] mem_r [MEM_DEPTH];
    logic [DATA_W-1:0] mem_q_r;

    logic              scl_meta_r;
    logic              scl_sync_r;
    logic              scl_prev_r;
    logic              sda_meta_r;
    logic              sda_sync_r;
    logic              sda_prev_r;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;

    eep_state_t        state_r;
    eep_state_t        state_nxt;
    eep_state_t        post_r;
    eep_state_t        post_nxt;
    logic [2:0]        cnt_r;
    logic [2:0]        cnt_nxt;
    logic [DATA_W-1:0] shift_r;
    logic [DATA_W-1:0] shift_nxt;
    logic [MEM_AW-1:0] addr_r;
    logic [MEM_AW-1:0] addr_nxt;
    logic [1:0]        upper_r;
    logic [1:0]        upper_nxt;
    logic              oe_r;
    logic              oe_nxt;
    logic [DATA_W-1:0] rx_byte;

    logic              flush;
    logic [MEM_AW-1:0] flush_addr;
    logic              pop;
    logic [MEM_AW-1:0] pf_addr_r;
    logic [MEM_AW-1:0] pf_addr_nxt;
    logic [MEM_AW-1:0] pend_addr_r;
    logic [MEM_AW-1:0] pend_addr_nxt;
    logic              rd_pend_r;
    logic              rd_pend_nxt;
    logic              buf_in_ready;
    logic              buf_out_valid;
    eep_word_t         buf_in;
    eep_word_t         buf_out;

    // The first flop of each pin feeds only the second one.
    always_ff @(posedge i_clk) begin
        scl_meta_r <= i_scl;
        scl_sync_r <= scl_meta_r;
        scl_prev_r <= scl_sync_r;
        sda_meta_r <= i_sda;
        sda_sync_r <= sda_meta_r;
        sda_prev_r <= sda_sync_r;
    end

    assign scl_rise  = scl_sync_r && !scl_prev_r;
    assign scl_fall  = !scl_sync_r && scl_prev_r;
    assign start_det = scl_sync_r && scl_prev_r && sda_prev_r && !sda_sync_r;
    assign stop_det  = scl_sync_r && scl_prev_r && !sda_prev_r && sda_sync_r;
    assign rx_byte   = {shift_r[DATA_W-2:0], sda_sync_r};

    always_comb begin
        state_nxt  = state_r;
        post_nxt   = post_r;
        cnt_nxt    = cnt_r;
        shift_nxt  = shift_r;
        addr_nxt   = addr_r;
        upper_nxt  = upper_r;
        oe_nxt     = oe_r;
        flush      = 1'b0;
        flush_addr = addr_r;
        pop        = 1'b0;
        if (stop_det) begin
            state_nxt = ST_IDLE;
            oe_nxt    = 1'b0;
        end else if (start_det) begin
            state_nxt = ST_RX_DEV;
            cnt_nxt   = 3'h0;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                ST_RX_DEV, ST_RX_MEM: begin
                    if (scl_rise) begin
                        shift_nxt = rx_byte;
                        cnt_nxt   = cnt_r + 3'h1;
                        if (cnt_r == LAST_BIT) begin
                            state_nxt = ST_ACK_WAIT;
                            if (state_r == ST_RX_MEM) begin
                                addr_nxt   = {upper_r, rx_byte};
                                flush      = 1'b1;
                                flush_addr = {upper_r, rx_byte};
                                post_nxt   = ST_IGNORE;
                            end else if (rx_byte[CODE_MSB:CODE_LSB]
                                         != DEV_CODE || i_wr_busy) begin
                                state_nxt = ST_IGNORE;
                            end else if (rx_byte[DIR_BIT] == DIR_READ) begin
                                flush    = 1'b1;
                                post_nxt = ST_TX_BIT;
                            end else begin
                                upper_nxt = rx_byte[UPPER_MSB:UPPER_LSB];
                                post_nxt  = ST_RX_MEM;
                            end
                        end
                    end
                end
                ST_ACK_WAIT: begin
                    if (scl_fall) begin
                        oe_nxt    = 1'b1;
                        state_nxt = ST_ACK_DRV;
                    end
                end
                ST_ACK_DRV, ST_TX_MORE: begin
                    if (scl_fall) begin
                        cnt_nxt   = 3'h0;
                        oe_nxt    = 1'b0;
                        state_nxt = post_r;
                        if (state_r == ST_TX_MORE || post_r == ST_TX_BIT) begin
                            // A drained buffer sends all ones; the prefetch
                            // runs far faster than the bus, so it stays full.
                            pop       = 1'b1;
                            shift_nxt = buf_out_valid ? buf_out.data : '1;
                            addr_nxt  = buf_out.addr + 1'b1;
                            oe_nxt    = buf_out_valid && !buf_out.data[DATA_W-1];
                            state_nxt = ST_TX_BIT;
                        end
                    end
                end
                ST_TX_BIT: begin
                    if (scl_fall) begin
                        if (cnt_r == LAST_BIT) begin
                            oe_nxt    = 1'b0;
                            state_nxt = ST_TX_ACK;
                        end else begin
                            cnt_nxt   = cnt_r + 3'h1;
                            shift_nxt = {shift_r[DATA_W-2:0], 1'b1};
                            oe_nxt    = !shift_r[DATA_W-2];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        // A high slot ends the transfer until the next STOP or START.
                        if (sda_sync_r) begin
                            state_nxt = ST_IGNORE;
                        end else begin
                            state_nxt = ST_TX_MORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ST_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            post_r  <= ST_IDLE;
            cnt_r   <= 3'h0;
            shift_r <= '0;
            addr_r  <= ADDR_RESET;
            upper_r <= UPPER_RESET;
            oe_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            post_r  <= post_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            addr_r  <= addr_nxt;
            upper_r <= upper_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // Prefetch: one array read in flight at a time, so a push always
    // finds room that was checked when the read was issued.
    always_comb begin
        pf_addr_nxt   = pf_addr_r;
        pend_addr_nxt = pend_addr_r;
        rd_pend_nxt   = 1'b0;
        if (flush) begin
            pf_addr_nxt = flush_addr;
        end else if (!rd_pend_r && buf_in_ready) begin
            rd_pend_nxt   = 1'b1;
            pend_addr_nxt = pf_addr_r;
            pf_addr_nxt   = pf_addr_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pf_addr_r   <= ADDR_RESET;
            pend_addr_r <= ADDR_RESET;
            rd_pend_r   <= 1'b0;
        end else begin
            pf_addr_r   <= pf_addr_nxt;
            pend_addr_r <= pend_addr_nxt;
            rd_pend_r   <= rd_pend_nxt;
        end
    end

    // The load port stands in for the write path kept outside this block.
    always_ff @(posedge i_clk) begin
        if (i_load_en) begin
            mem_r[i_load_addr] <= i_load_data;
        end
        mem_q_r <= mem_r[pf_addr_r];
    end

    assign buf_in = '{addr: pend_addr_r, data: mem_q_r};

    eep_fifo2 #(
        .W     ($bits(eep_word_t)),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_flush (flush),
        .i_valid (rd_pend_r),
        .o_ready (buf_in_ready),
        .i_data  (buf_in),
        .o_valid (buf_out_valid),
        .i_ready (pop),
        .o_data  (buf_out)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_sda_o  <= SDA_LOW;
            o_sda_oe <= 1'b0;
        end else begin
            o_sda_o  <= SDA_LOW;
            o_sda_oe <= oe_nxt;
        end
    end

    assign o_cur_addr = addr_r;
endmodule
`default_nettype wire

// ---- sim/eep_read_checker.sv ----
// Pin-level assertions for the EEPROM read engine.
// Assumes bus pins change only between rising edges of i_clk.
`timescale 1ns/1ps
`default_nettype none
module eep_read_checker import eep_pkg::*; (
    input wire logic              i_clk,
    input wire logic              i_srst,
    input wire logic              i_scl,
    input wire logic              i_sda,
    input wire logic              o_sda_o,
    input wire logic              o_sda_oe,
    input wire logic              i_wr_busy,
    input wire logic              i_load_en,
    input wire logic [MEM_AW-1:0] i_load_addr,
    input wire logic [DATA_W-1:0] i_load_data,
    input wire logic [MEM_AW-1:0] o_cur_addr
);
    logic scl_q;
    logic sda_q;
    logic quiet_r;
    logic quiet_nxt;
    logic start_ev;
    logic stop_ev;

    assign start_ev = i_scl && scl_q && sda_q && !i_sda;
    assign stop_ev  = i_scl && scl_q && !sda_q && i_sda;

    // The bus counts as quiet from a STOP until the next START.
    always_comb begin
        quiet_nxt = quiet_r;
        if (i_srst || start_ev) begin
            quiet_nxt = 1'b0;
        end else if (stop_ev) begin
            quiet_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        scl_q   <= i_scl;
        sda_q   <= i_sda;
        quiet_r <= quiet_nxt;
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_pin_low: assert property (o_sda_o == 1'b0)
        else $error("drive value not low");
    chk_reset_idle: assert property (disable iff (1'b0)
        i_srst |=> !o_sda_oe && o_cur_addr == ADDR_RESET)
        else $error("reset left line or address set");
    chk_oe_on_fall: assert property ($changed(o_sda_oe) |->
        !$past(i_scl, 3) && ($past(i_scl, 5) || $past(i_scl, 6)))
        else $error("drive changed away from a clock fall");
    chk_oe_stands: assert property ($rose(o_sda_oe) |=>
        o_sda_oe [*6])
        else $error("low level shorter than a clock period");
    chk_addr_step: assert property (
        $changed(o_cur_addr) && !$past(i_scl, 3) |->
        o_cur_addr == $past(o_cur_addr) + 10'h001)
        else $error("address did not step by one");
    chk_idle_quiet: assert property (quiet_r |-> !o_sda_oe)
        else $error("line driven after stop");
    chk_start_quiet: assert property (start_ev |=>
        !o_sda_oe [*8])
        else $error("line driven during address byte");
    chk_busy_no_ack: assert property ($rose(o_sda_oe) |->
        !$past(i_wr_busy, 4))
        else $error("answered while write cycle busy");
endmodule

bind eep_read_engine eep_read_checker u_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_wr_busy(i_wr_busy),
    .i_load_en(i_load_en), .i_load_addr(i_load_addr),
    .i_load_data(i_load_data), .o_cur_addr(o_cur_addr)
);
`default_nettype wire

// ---- sim/eep_bus_ctrl.sv ----
// Behavioural two-wire bus controller facing the read engine.
// Assumes a pull-up on the data line; o_sda_oe high pulls it low.
`timescale 1ns/1ps
`default_nettype none
module eep_bus_ctrl (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // One eight-clock period; data moves only while the clock is low.
    task automatic bit_cyc(input logic b, output logic s);
        wait_clk(2);
        o_sda_oe = ~b;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(3);
        s = i_sda;
        wait_clk(1);
        o_scl = 1'b0;
    endtask

    // Serves as repeated START too, so the line is released first.
    task automatic start_cond();
        wait_clk(2);
        o_sda_oe = 1'b0;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(4);
        o_sda_oe = 1'b1;
        wait_clk(4);
        o_scl = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(2);
        o_sda_oe = 1'b1;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(4);
        o_sda_oe = 1'b0;
        wait_clk(8);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            d[i] = s;
        end
        bit_cyc(~more, s);
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the read engine with a bus controller model.
// Assumes the array is preloaded through the load port before reads.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import eep_pkg::*;
    typedef struct packed {
        logic [9:0] addr;
        logic [3:0] n;
        logic [7:0] first;
        logic [9:0] last;
    } eep_row_t;
    localparam eep_row_t ROWS [4] = '{'{10'h000, 4'h1, 8'h5a, 10'h001},
        '{10'h155, 4'h4, 8'h4f, 10'h159}, '{10'h2aa, 4'h2, 8'h70, 10'h2ac},
        '{10'h3ff, 4'h3, 8'h65, 10'h002}};
    logic              clk;
    logic              srst;
    logic              wr_busy;
    logic              load_en;
    logic [MEM_AW-1:0] load_addr;
    logic [DATA_W-1:0] load_data;
    logic              dut_sda_o;
    logic              dut_sda_oe;
    logic [MEM_AW-1:0] cur_addr;
    logic              scl;
    logic              m_oe;
    wire               sda;
    int                mismatches;
    int                n_checks;

    assign sda = (dut_sda_oe ? dut_sda_o : 1'b1) & ~m_oe;
    always #25 clk = ~clk;

    eep_read_engine u_dut (.i_clk(clk), .i_srst(srst), .i_scl(scl),
        .i_sda(sda), .o_sda_o(dut_sda_o), .o_sda_oe(dut_sda_oe),
        .i_wr_busy(wr_busy), .i_load_en(load_en), .i_load_addr(load_addr),
        .i_load_data(load_data), .o_cur_addr(cur_addr));
    eep_bus_ctrl u_ctrl (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(m_oe));

    function automatic logic [7:0] pat(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h00} ^ 8'h5a;
    endfunction

    task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check_val({9'h000, got}, {9'h000, exp});
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        check_flag(dut_sda_oe, 1'b0);
        check_val(cur_addr, 10'h000);
    endtask

    // Without sel the read starts at whatever address the engine holds.
    task automatic read_seq(input logic sel, input logic [9:0] a,
                            input int n, input logic [7:0] first,
                            input logic [9:0] last);
        logic       ack;
        logic [7:0] d;
        logic [7:0] e;
        if (sel) begin
            u_ctrl.start_cond();
            u_ctrl.send_byte({DEV_CODE, a[9:8], 2'b00}, ack);
            check_flag(ack, 1'b1);
            u_ctrl.send_byte(a[7:0], ack);
            check_flag(ack, 1'b1);
        end
        u_ctrl.start_cond();
        u_ctrl.send_byte({DEV_CODE, 4'h1}, ack);
        check_flag(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_ctrl.recv_byte(i < n - 1, d);
            e = (i == 0) ? first : pat(a + 10'(i));
            check_val({2'b00, d}, {2'b00, e});
        end
        u_ctrl.stop_cond();
        check_val(cur_addr, last);
    endtask

    task automatic refused(input logic [7:0] b);
        logic ack;
        u_ctrl.start_cond();
        u_ctrl.send_byte(b, ack);
        check_flag(ack, 1'b0);
        u_ctrl.stop_cond();
    endtask

    initial begin
        #(20000 * 50);
        mismatches++;
        report_and_stop();
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        wr_busy = 1'b0;
        load_en = 1'b0;
        load_addr = 10'h000;
        load_data = 8'h00;
        mismatches = 0;
        n_checks = 0;
        do_reset();
        for (int a = 0; a < MEM_DEPTH; a++) begin
            @(negedge clk);
            load_en = 1'b1;
            load_addr = 10'(a);
            load_data = pat(10'(a));
        end
        @(negedge clk);
        load_en = 1'b0;
        for (int r = 0; r < 4; r++) begin
            read_seq(1'b1, ROWS[r].addr, int'(ROWS[r].n),
                     ROWS[r].first, ROWS[r].last);
        end
        read_seq(1'b0, 10'h002, 2, 8'h58, 10'h004);
        refused({4'hb, 4'h1});
        wr_busy = 1'b1;
        refused({DEV_CODE, 4'h1});
        wr_busy = 1'b0;
        read_seq(1'b0, 10'h004, 1, 8'h5e, 10'h005);
        do_reset();
        read_seq(1'b0, 10'h000, 1, 8'h5a, 10'h001);
        report_and_stop();
    end
endmodule
`default_nettype wire
